//--- logic/pirq_top.sv
// Interrupt configuration register, event flags and interrupt pin drive.
// Assumes a register port on core_clk from the serial host interface.
//
// Operation
// - Enable bit 0 raises an interrupt on the active-energy pulse leading edge.
// - Enable bit 1 raises an interrupt on the reactive-energy pulse leading edge.
// - Enable bit 2 raises an interrupt on the auxiliary Y pulse leading edge.
// - Enable bit 3 raises an interrupt on the auxiliary X pulse leading edge.
// - Enable bit 4 raises an interrupt when an accumulation interval ends.
// - Compute pass end sets status flag bit 5.
// - Enable bit 7 raises an interrupt when supply status changes.
// - Polarity bits 11:8 pick falling (0) or rising (1) edge per pulse.
// - Bit 15 makes the active-low interrupt pin open drain, else push-pull.
// - Status flags clear automatically after the host reads the status register.
`timescale 1ns/1ps
module pirq_top (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire pirq_pkg::pirq_addr_t reg_addr,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    input  wire pirq_pkg::pirq_word_t reg_wdata,
    output      pirq_pkg::pirq_word_t reg_rdata,
    input  wire logic             active_energy_pulse,
    input  wire logic             reactive_energy_pulse,
    input  wire logic             aux_x_pulse,
    input  wire logic             aux_y_pulse,
    input  wire logic             data_ready_evt,
    input  wire logic             compute_done_evt,
    input  wire logic             system_supply,
    output      logic             irq_n_out,
    output      logic             irq_n_oe
);
    import pirq_pkg::*;

    pirq_word_t irq_config_reg;
    logic [8:0] flags_reg;
    logic [8:0] flags_next;
    logic [8:0] en_map;
    logic       irq_reg;
    pirq_word_t rdata_reg;
    pirq_word_t stat_view;
    logic       rd_stat;
    logic       wr_cfg;

    pirq_evt_if evt_bus ();

    function automatic logic addr_hit(input pirq_addr_t a, input pirq_addr_t off);
        addr_hit = (a == off);
    endfunction : addr_hit

    pirq_edge_detect u_edge (
        .core_clk         (core_clk),
        .reset            (reset),
        .pulse_in         ({aux_y_pulse, aux_x_pulse, reactive_energy_pulse,
                            active_energy_pulse}),
        .data_ready_evt   (data_ready_evt),
        .compute_done_evt (compute_done_evt),
        .system_supply    (system_supply),
        .evt_bus          (evt_bus.src)
    );

    // **********************************************************************
    // Configuration register.
    // **********************************************************************
    assign wr_cfg      = reg_wr & addr_hit(reg_addr, PIRQ_CFG_OFF);
    assign rd_stat     = reg_rd & addr_hit(reg_addr, PIRQ_STAT_OFF);
    assign evt_bus.pol = irq_config_reg[PIRQ_POL_LSB +: 4];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_config_reg <= PIRQ_CFG_RESET;
        end else if (wr_cfg) begin
            irq_config_reg <= reg_wdata & PIRQ_CFG_WMASK;
        end
    end

    // **********************************************************************
    // Event flags, cleared on read with new events winning.
    // **********************************************************************
    assign flags_next = (flags_reg & ~{9{rd_stat}}) | {1'b0, evt_bus.evt};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags_reg <= PIRQ_FLAG_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign stat_view = {7'h00, flags_reg[PIRQ_RST_FLAG], 2'b00, flags_reg[5:0],
                        7'h00, flags_reg[PIRQ_RST_FLAG], flags_reg[7:0]};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (addr_hit(reg_addr, PIRQ_CFG_OFF)) begin
                rdata_reg <= irq_config_reg;
            end else if (addr_hit(reg_addr, PIRQ_STAT_OFF)) begin
                rdata_reg <= stat_view;
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end
    assign reg_rdata = rdata_reg;

    // **********************************************************************
    // Interrupt request and pin drive.
    // **********************************************************************
    // Flag bit 2 is the X pulse and bit 3 the Y pulse; their enables are swapped.
    assign en_map = {1'b0, irq_config_reg[7], 1'b0, irq_config_reg[5],
                     irq_config_reg[4], irq_config_reg[2], irq_config_reg[3],
                     irq_config_reg[1], irq_config_reg[0]};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flags_next & en_map);
        end
    end

    assign irq_n_out = irq_config_reg[PIRQ_OD_BIT] ? 1'b0 : ~irq_reg;
    assign irq_n_oe  = irq_config_reg[PIRQ_OD_BIT] ? irq_reg : 1'b1;

    // **********************************************************************
    // Assertions.
    // **********************************************************************
    property p_active_rise;
        @(posedge core_clk) disable iff (reset)
        $rose(active_energy_pulse) && irq_config_reg[8] && irq_config_reg[0] |-> ##1 irq_reg;
    endproperty
    a_active_rise: assert property (p_active_rise) else $error("Active pulse irq missing.");

    property p_reactive_fall;
        @(posedge core_clk) disable iff (reset)
        $fell(reactive_energy_pulse) && !irq_config_reg[9] && irq_config_reg[1]
            |-> ##1 irq_reg;
    endproperty
    a_reactive_fall: assert property (p_reactive_fall) else $error("Reactive irq missing.");

    property p_aux_y;
        @(posedge core_clk) disable iff (reset)
        $fell(aux_y_pulse) && !irq_config_reg[11] && irq_config_reg[2] |=> irq_reg && flags_reg[3];
    endproperty
    a_aux_y: assert property (p_aux_y) else $error("Aux Y irq missing.");

    property p_aux_x;
        @(posedge core_clk) disable iff (reset)
        $rose(aux_x_pulse) && irq_config_reg[10] && irq_config_reg[3] |=> irq_reg && flags_reg[2];
    endproperty
    a_aux_x: assert property (p_aux_x) else $error("Aux X irq missing.");

    property p_data_ready;
        @(posedge core_clk) disable iff (reset)
        data_ready_evt && irq_config_reg[4] && !wr_cfg |=> irq_reg;
    endproperty
    a_data_ready: assert property (p_data_ready) else $error("Data ready irq missing.");

    property p_compute_irq;
        @(posedge core_clk) disable iff (reset)
        compute_done_evt && irq_config_reg[5] && !wr_cfg |=> irq_reg;
    endproperty
    a_compute_irq: assert property (p_compute_irq) else $error("Compute irq missing.");

    property p_compute_flag;
        @(posedge core_clk) disable iff (reset)
        compute_done_evt |=> flags_reg[5] && stat_view[21];
    endproperty
    a_compute_flag: assert property (p_compute_flag) else $error("Compute flag not set.");

    property p_supply;
        @(posedge core_clk) disable iff (reset)
        evt_bus.evt[7] && irq_config_reg[7] && !wr_cfg |=> irq_reg && flags_reg[7];
    endproperty
    a_supply: assert property (p_supply) else $error("Supply change irq missing.");

    property p_wrong_edge;
        @(posedge core_clk) disable iff (reset)
        $rose(active_energy_pulse) && !irq_config_reg[8] && !flags_reg[0] |=> !flags_reg[0];
    endproperty
    a_wrong_edge: assert property (p_wrong_edge) else $error("Wrong edge set a flag.");

    property p_pin_drive;
        @(posedge core_clk) disable iff (reset)
        irq_config_reg[PIRQ_OD_BIT] ? (irq_n_oe == irq_reg && !irq_n_out)
                                    : (irq_n_oe && irq_n_out == !irq_reg);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("Interrupt pin drive wrong.");

    property p_clear_on_read;
        @(posedge core_clk) disable iff (reset)
        rd_stat && evt_bus.evt == 8'h00
            |=> flags_reg == 9'h000 ##1 !irq_reg || $past(evt_bus.evt) != 8'h00;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("Flags not cleared.");

    c_pulse_irq: cover property (@(posedge core_clk) disable iff (reset)
        $rose(aux_x_pulse) ##1 irq_reg);
    c_read_clear: cover property (@(posedge core_clk) disable iff (reset)
        flags_reg != 9'h000 && rd_stat ##1 flags_reg == 9'h000);
    c_open_drain: cover property (@(posedge core_clk) disable iff (reset)
        irq_config_reg[PIRQ_OD_BIT] && irq_n_oe);
    c_set_and_clear: cover property (@(posedge core_clk) disable iff (reset)
        rd_stat && compute_done_evt ##1 flags_reg[5]);
endmodule : pirq_top

//--- logic/pirq_pkg.sv
// Shared constants and types for the pulse interrupt configuration block.
// Assumes a device-internal register port on the same clock as the block.
package pirq_pkg;
    typedef logic [11:0] pirq_addr_t;
    typedef logic [31:0] pirq_word_t;

    localparam pirq_addr_t PIRQ_CFG_OFF    = 12'h30F;
    localparam pirq_addr_t PIRQ_STAT_OFF   = 12'h310;
    localparam pirq_word_t PIRQ_CFG_RESET  = 32'h0000_8000;
    localparam pirq_word_t PIRQ_CFG_WMASK  = 32'h0000_8FBF;
    localparam logic [8:0] PIRQ_FLAG_RESET = 9'h100;
    localparam int         PIRQ_POL_LSB    = 8;
    localparam int         PIRQ_OD_BIT     = 15;
    localparam int         PIRQ_RST_FLAG   = 8;
    localparam int         PIRQ_NUM_PULSE  = 4;
endpackage : pirq_pkg

//--- logic/pirq_evt_if.sv
// Carries edge polarity in and one-cycle event strobes out of the edge detector.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface pirq_evt_if;
    logic [3:0] pol;
    logic [7:0] evt;
    modport src (input pol, output evt);
    modport dst (output pol, input evt);
endinterface : pirq_evt_if

//--- logic/pirq_edge_detect.sv
// Edge detection of the four meter pulses and the supply status.
// Assumes pulses come from core_clk logic and supply status from an analog comparator.
`timescale 1ns/1ps
module pirq_edge_detect (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic [3:0] pulse_in,
    input  wire logic data_ready_evt,
    input  wire logic compute_done_evt,
    input  wire logic system_supply,
    pirq_evt_if.src   evt_bus
);
    import pirq_pkg::*;

    logic [3:0] pulse_prev_reg;
    logic       supply_meta_reg;
    logic       supply_sync_reg;
    logic       supply_prev_reg;
    logic [2:0] supply_arm_reg;
    logic [3:0] pulse_evt;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pulse_prev_reg <= 4'h0;
        end else begin
            pulse_prev_reg <= pulse_in;
        end
    end

    // **********************************************************************
    // Supply status synchroniser and change detector.
    // **********************************************************************
    always_ff @(posedge core_clk) begin
        if (reset) begin
            supply_meta_reg <= 1'b0;
            supply_sync_reg <= 1'b0;
            supply_prev_reg <= 1'b0;
            supply_arm_reg  <= 3'h0;
        end else begin
            supply_meta_reg <= system_supply;
            supply_sync_reg <= supply_meta_reg;
            supply_prev_reg <= supply_sync_reg;
            supply_arm_reg  <= {supply_arm_reg[1:0], 1'h1};
        end
    end

    // Each pulse fires on the edge its polarity bit selects.
    for (genvar i = 0; i < PIRQ_NUM_PULSE; i++) begin : g_edge
        assign pulse_evt[i] = evt_bus.pol[i] ? (pulse_in[i] & ~pulse_prev_reg[i])
                                             : (~pulse_in[i] & pulse_prev_reg[i]);
    end

    // Change detection waits until the synchroniser holds real samples, so no false
    // supply change follows reset.
    assign evt_bus.evt = {supply_arm_reg[2] & (supply_sync_reg ^ supply_prev_reg), 1'b0,
                          compute_done_evt, data_ready_evt, pulse_evt};
endmodule : pirq_edge_detect

//--- testbench/pirq_host_model.sv
// Host side view of the interrupt pin.
// Assumes the board pulls the pin up while nobody drives it.
`timescale 1ns/1ps
module pirq_host_model (
    input  wire logic irq_n_out,
    input  wire logic irq_n_oe,
    output wire logic irq_pin_level
);
    // A released pin floats to the pull-up level.
    assign irq_pin_level = irq_n_oe ? irq_n_out : 1'b1;
endmodule : pirq_host_model

//--- testbench/tb_top.sv
// Self-checking bench for the pulse interrupt configuration block.
// Assumes pirq_pkg, pirq_top and the host model are compiled first.
`timescale 1ns/1ps
module tb_top;
    import pirq_pkg::*;
    typedef struct {pirq_word_t e; pirq_word_t m;} pirq_note_t;
    logic       core_clk  = 0;
    logic       reset     = 1;
    pirq_addr_t reg_addr  = '0;
    logic       reg_wr    = 0;
    logic       reg_rd    = 0;
    pirq_word_t reg_wdata = '0;
    pirq_word_t reg_rdata;
    logic [3:0] pl        = '0;
    logic       drdy      = 0;
    logic       cdone     = 0;
    logic       supply    = 0;
    logic       irq_n_out;
    logic       irq_n_oe;
    logic       pin;
    logic       rd_seen   = 0;
    int         fail_count  = 0;
    int         check_count = 0;
    pirq_note_t notes[$];
    pirq_note_t nt;

    pirq_top uut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .active_energy_pulse(pl[0]), .reactive_energy_pulse(pl[1]), .aux_x_pulse(pl[2]),
        .aux_y_pulse(pl[3]), .data_ready_evt(drdy), .compute_done_evt(cdone),
        .system_supply(supply), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    pirq_host_model hm (.irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .irq_pin_level(pin));

    // ****************************************
    // Helpers.
    // ****************************************
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    task automatic cmp(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : cmp

    // A read notes its expected word; a write ignores d as expectation.
    task automatic acc(input logic w, input pirq_addr_t a, input pirq_word_t d,
                       input pirq_word_t m);
        step(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        if (!w) notes.push_back('{d, m});
        step(1);
        reg_wr = 0;
        reg_rd = 0;
    endtask : acc

    task automatic pin_chk(input logic irq, input logic od);
        cmp(pin === !irq && irq_n_oe === (od ? irq : 1'b1), "irq pin");
    endtask : pin_chk

    task automatic evt(input int k, input pirq_word_t cfg, input logic irq);
        acc(1, PIRQ_CFG_OFF, cfg, '0);
        if (k == 4) drdy = 1;
        if (k == 5) cdone = 1;
        if (k == 7) supply = !supply;
        step(1);
        drdy = 0;
        cdone = 0;
        step(5);
        pin_chk(irq, 0);
        acc(0, PIRQ_STAT_OFF, (k == 7) ? 32'h80 : (32'h10001 << k), '1);
    endtask : evt

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // Result monitor.
    // ****************************************
    always @(posedge core_clk) begin
        if (rd_seen) begin
            nt = notes.pop_front();
            cmp(((reg_rdata ^ nt.e) & nt.m) === '0, "read data");
        end
        rd_seen <= reg_rd;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        wrap_up();
    end

    // ****************************************
    // Tests.
    // ****************************************
    initial begin
        pirq_word_t rnd;
        pirq_word_t cfg;
        int         i;
        int         p;
        rnd = $urandom(22);
        step(2);
        reset = 0;
        pin_chk(0, 1);
        acc(0, PIRQ_CFG_OFF, PIRQ_CFG_RESET, '1);
        acc(0, PIRQ_STAT_OFF, 32'h0100_0100, '1);
        acc(0, PIRQ_STAT_OFF, 32'h0000_0000, '1);
        acc(0, 12'h311, 32'h0000_0000, '1);
        rnd = $urandom;
        acc(1, PIRQ_CFG_OFF, rnd, '0);
        acc(0, PIRQ_CFG_OFF, rnd & PIRQ_CFG_WMASK, '1);
        $display("test registers done");
        for (i = 0; i < 4; i++) begin
            for (p = 0; p < 2; p++) begin
                cfg = (32'h1 << ((i < 2) ? i : 5 - i)) | (p << (8 + i)) | (p << 15);
                pl[i] = !p;
                acc(1, PIRQ_CFG_OFF, cfg, '0);
                step(3);
                acc(0, PIRQ_STAT_OFF, '0, '0);
                step(2);
                pl[i] = p;
                step(4);
                pin_chk(1, p);
                acc(0, PIRQ_STAT_OFF, 32'h10001 << i, '1);
                step(2);
                pin_chk(0, p);
                pl[i] = !p;
                step(4);
                acc(0, PIRQ_STAT_OFF, '0, '1);
            end
        end
        $display("test pulses done");
        evt(4, 32'h0000_00A0, 0);
        evt(4, 32'h0000_0010, 1);
        evt(5, 32'h0000_0020, 1);
        evt(7, 32'h0000_0080, 1);
        evt(7, 32'h0000_0000, 0);
        $display("test events done");
        reset = 1;
        step(2);
        reset = 0;
        pin_chk(0, 1);
        acc(0, PIRQ_CFG_OFF, PIRQ_CFG_RESET, '1);
        acc(0, PIRQ_STAT_OFF, 32'h0100_0100, '1);
        acc(0, PIRQ_STAT_OFF, 32'h0000_0000, '1);
        $display("test reset done");
        wrap_up();
    end
endmodule : tb_top
